/* logic/cem_defines.svh */
/*
 * register offsets, field positions, reset values and cycle counts of the
 * cipher engine mode control block.
 * assumes: included by bare name; defines only.
 */
`ifndef CEM_DEFINES_SVH
`define CEM_DEFINES_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define CEM_OFF_CONTROL       8'h50
`define CEM_OFF_MODE_CONTROL  8'h54
`define CEM_OFF_STATUS        8'h58
`define CEM_OFF_IRQ_STATUS    8'h70
`define CEM_OFF_IRQ_MASK      8'h74

// ****************************************************************
// companion control register fields (write one to act)
// ****************************************************************
`define CEM_CTL_CLEAR_IRQ     31
`define CEM_CTL_LOAD_MAC      26
`define CEM_CTL_CLEAR_MEM     25
`define CEM_CTL_START         24

// ****************************************************************
// mode control register fields
// ****************************************************************
`define CEM_MC_MASK_IRQ       31
`define CEM_MC_SELF_TEST      26
`define CEM_MC_CTR            25
`define CEM_MC_MAC            24
`define CEM_MC_BYPASS         2
`define CEM_MC_NORMAL         1
`define CEM_MC_ON             0
`define CEM_MC_RESET          32'h0000_0000

// ****************************************************************
// status register fields
// ****************************************************************
`define CEM_ST_DONE           26
`define CEM_ST_TEST_PASS      25

// ****************************************************************
// interrupt status and mask fields
// ****************************************************************
`define CEM_IRQ_DONE          0
`define CEM_IRQ_TEST_FAIL     1
`define CEM_IRQ_WIDTH         2

// ****************************************************************
// timing: clocks per cipher function
// ****************************************************************
`define CEM_PHASE_CYCLES      13

`endif

/* logic/cem_pkg.sv */
/*
 * types of the cipher engine mode control block.
 * assumes: compiled before the modules that name it.
 */
package cem_pkg;

    // operation sequencer states
    typedef enum logic [1:0] {
        st_idle,
        st_ctr,
        st_mac,
        st_test
    } cem_op_state_t;

endpackage : cem_pkg

/* logic/cem_op_timer.sv */
/*
 * operation sequencer: counts the clocks of each cipher function and
 * signals the end of a started operation.
 * assumes: start is a one-cycle pulse from the same clock, given only
 * while busy is low.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cem_defines.svh"

module cem_op_timer #(
    parameter logic [4:0] PHASE_CYCLES = 5'(`CEM_PHASE_CYCLES)
) (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic start,
    input  wire logic ctr_en,
    input  wire logic mac_en,
    input  wire logic test_en,
    output var  logic run_ctr_ff,
    output var  logic run_mac_ff,
    output var  logic run_test_ff,
    output var  logic busy_ff,
    output var  logic done_ff
);

    cem_pkg::cem_op_state_t state_ff;
    logic [4:0]             cnt_ff;
    logic                   mac_next_ff;

    // ************************************************************
    // phase sequencing
    // ************************************************************
    // self test has priority; counter phase runs before mac phase
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_ff    <= cem_pkg::st_idle;
            cnt_ff      <= 5'h00;
            mac_next_ff <= 1'b0;
            done_ff     <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            case (state_ff)
                cem_pkg::st_idle: begin
                    cnt_ff      <= PHASE_CYCLES - 5'h01;
                    mac_next_ff <= ctr_en & mac_en & ~test_en;
                    if (start && test_en) begin
                        state_ff <= cem_pkg::st_test;
                    end else if (start && ctr_en) begin
                        state_ff <= cem_pkg::st_ctr;
                    end else if (start && mac_en) begin
                        state_ff <= cem_pkg::st_mac;
                    end
                end
                default: begin
                    if (cnt_ff != 5'h00) begin
                        cnt_ff <= cnt_ff - 5'h01;
                    end else if (mac_next_ff) begin
                        // second function doubles the length
                        mac_next_ff <= 1'b0;
                        cnt_ff      <= PHASE_CYCLES - 5'h01;
                        state_ff    <= cem_pkg::st_mac;
                    end else begin
                        state_ff <= cem_pkg::st_idle;
                        done_ff  <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // phase outputs, registered with the next state
    // ************************************************************
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            run_ctr_ff  <= 1'b0;
            run_mac_ff  <= 1'b0;
            run_test_ff <= 1'b0;
            busy_ff     <= 1'b0;
        end else if (state_ff == cem_pkg::st_idle) begin
            run_test_ff <= start & test_en;
            run_ctr_ff  <= start & ~test_en & ctr_en;
            run_mac_ff  <= start & ~test_en & ~ctr_en & mac_en;
            busy_ff     <= start & (test_en | ctr_en | mac_en);
        end else if (cnt_ff == 5'h00) begin
            run_test_ff <= 1'b0;
            run_ctr_ff  <= 1'b0;
            run_mac_ff  <= mac_next_ff;
            busy_ff     <= mac_next_ff;
        end
    end

endmodule : cem_op_timer
`default_nettype wire

/* logic/cem_mode_ctrl.sv */
/*
 * cipher engine mode control: apb register slave, persistent mode bits,
 * start and housekeeping strobes, done and self-test status, interrupt.
 * assumes: apb master on the same clock; the cipher datapath reads the
 * mode outputs and reports the self-test verdict on test_ok.
 */
// The APB register port is this design's own decision.
// Notes on behaviour
// - mode bits other than the sticky normal bit 1 keep written values; writing them never starts an operation
// - counter mode alone: operation runs counter encryption, 13 clocks
// - mac mode alone: started operation computes chained mac, 13 clocks
// - both modes set: both functions run, 26 clocks in total
// - bit 31 masks the interrupt; clear at reset, interrupt enabled
// - bit 26 selects self test for started operations; resets to zero
// - bypass bit 2 passes data unmodified; clear means data encrypted
// - after reset the engine is in boot mode using the secret key
// - writing one to bit 1 enters normal mode, using programmed key
// - once normal mode is set, writes of zero to it are ignored
// - only a system reset brings the engine back to boot mode
// - bit 0 enables the engine; clear at reset means disabled
// - start bit of companion control register begins selected operation
// - finished operation sets done flag; results are then valid
// - failed self test makes engine unusable, results forced to zero
`timescale 1ns/1ps
`default_nettype none
`include "cem_defines.svh"

module cem_mode_ctrl #(
    parameter logic [4:0] PHASE_CYCLES = 5'(`CEM_PHASE_CYCLES)
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        test_ok,
    output var  logic        engine_enable,
    output var  logic        normal_key,
    output var  logic        bypass,
    output var  logic        run_ctr,
    output var  logic        run_mac,
    output var  logic        run_test,
    output var  logic        busy,
    output var  logic        result_zero,
    output var  logic        clear_mem,
    output var  logic        load_mac,
    output var  logic        irq
);

    // ************************************************************
    // state
    // ************************************************************
    localparam logic [31:0] MODE_RESET = `CEM_MC_RESET;
    logic        on_ff;
    logic        normal_ff;
    logic        bypass_ff;
    logic        mac_en_ff;
    logic        ctr_en_ff;
    logic        self_test_ff;
    logic        mask_irq_ff;
    logic        done_ff;
    logic        pass_ff;
    logic        failed_ff;
    logic        test_pend_ff;
    logic        clear_mem_ff;
    logic        load_mac_ff;
    logic        irq_ff;
    logic [1:0]  irq_stat_ff;
    logic [1:0]  irq_mask_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        op_done;
    logic        wr_en;
    logic        start_req;
    logic        clear_done;
    logic [31:0] nxt_prdata;
    logic        nxt_slverr;
    logic [31:0] mode_word;
    logic [31:0] status_word;
    logic [1:0]  irq_events;

    // ************************************************************
    // apb access
    // ************************************************************
    // write takes effect at the completing access edge
    assign wr_en = psel & penable & pready_ff & pwrite;

    // ready rises at the end of setup, so no access has a wait state
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= psel & ~pready_ff;
            prdata_ff  <= nxt_prdata;
            pslverr_ff <= psel & ~pready_ff & nxt_slverr;
        end
    end

    // readable images; reserved bits stay zero
    always_comb begin
        mode_word                   = 32'h0000_0000;
        mode_word[`CEM_MC_MASK_IRQ]  = mask_irq_ff;
        mode_word[`CEM_MC_SELF_TEST] = self_test_ff;
        mode_word[`CEM_MC_CTR]       = ctr_en_ff;
        mode_word[`CEM_MC_MAC]       = mac_en_ff;
        mode_word[`CEM_MC_BYPASS]    = bypass_ff;
        mode_word[`CEM_MC_NORMAL]    = normal_ff;
        mode_word[`CEM_MC_ON]        = on_ff;
        status_word                 = 32'h0000_0000;
        status_word[`CEM_ST_DONE]      = done_ff;
        status_word[`CEM_ST_TEST_PASS] = pass_ff;
    end

    // read mux and unmapped-address decode
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        nxt_slverr = 1'b0;
        if (paddr == `CEM_OFF_CONTROL) begin
            nxt_prdata = 32'h0000_0000; // strobes read as zero
        end else if (paddr == `CEM_OFF_MODE_CONTROL) begin
            nxt_prdata = mode_word;
        end else if (paddr == `CEM_OFF_STATUS) begin
            nxt_prdata = status_word;
        end else if (paddr == `CEM_OFF_IRQ_STATUS) begin
            nxt_prdata = {30'h0000_0000, irq_stat_ff};
        end else if (paddr == `CEM_OFF_IRQ_MASK) begin
            nxt_prdata = {30'h0000_0000, irq_mask_ff};
        end else begin
            nxt_slverr = 1'b1;
        end
    end

    // ************************************************************
    // mode control register
    // ************************************************************
    // plain storage: no write here starts the sequencer
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            on_ff        <= MODE_RESET[`CEM_MC_ON];
            bypass_ff    <= 1'b0;
            mac_en_ff    <= 1'b0;
            ctr_en_ff    <= 1'b0;
            self_test_ff <= 1'b0;
            mask_irq_ff  <= 1'b0;
        end else if (wr_en && paddr == `CEM_OFF_MODE_CONTROL) begin
            on_ff        <= pwdata[`CEM_MC_ON];
            bypass_ff    <= pwdata[`CEM_MC_BYPASS];
            mac_en_ff    <= pwdata[`CEM_MC_MAC];
            ctr_en_ff    <= pwdata[`CEM_MC_CTR];
            self_test_ff <= pwdata[`CEM_MC_SELF_TEST];
            mask_irq_ff  <= pwdata[`CEM_MC_MASK_IRQ];
        end
    end

    // boot to normal is one way; only reset returns to boot
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            normal_ff <= 1'b0;
        end else if (wr_en && paddr == `CEM_OFF_MODE_CONTROL &&
                     pwdata[`CEM_MC_NORMAL]) begin
            normal_ff <= 1'b1;
        end
    end

    // ************************************************************
    // companion control strobes
    // ************************************************************
    // start is honoured only when enabled, idle and not failed
    assign start_req = wr_en && paddr == `CEM_OFF_CONTROL &&
                       pwdata[`CEM_CTL_START] && on_ff && !busy &&
                       !failed_ff;
    assign clear_done = wr_en && paddr == `CEM_OFF_CONTROL &&
                        pwdata[`CEM_CTL_CLEAR_IRQ];

    // housekeeping pulses to the datapath, one cycle each
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            clear_mem_ff <= 1'b0;
            load_mac_ff  <= 1'b0;
        end else begin
            clear_mem_ff <= wr_en && paddr == `CEM_OFF_CONTROL &&
                            pwdata[`CEM_CTL_CLEAR_MEM];
            load_mac_ff  <= wr_en && paddr == `CEM_OFF_CONTROL &&
                            pwdata[`CEM_CTL_LOAD_MAC];
        end
    end

    // ************************************************************
    // operation sequencer
    // ************************************************************
    cem_op_timer #(
        .PHASE_CYCLES (PHASE_CYCLES)
    ) u_timer (
        .clock       (clock),
        .reset       (reset),
        .start       (start_req),
        .ctr_en      (ctr_en_ff),
        .mac_en      (mac_en_ff),
        .test_en     (self_test_ff),
        .run_ctr_ff  (run_ctr),
        .run_mac_ff  (run_mac),
        .run_test_ff (run_test),
        .busy_ff     (busy),
        .done_ff     (op_done)
    );

    // ************************************************************
    // done and self-test status
    // ************************************************************
    // a finishing operation wins over a clear in the same cycle
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            done_ff <= 1'b0;
        end else if (op_done) begin
            done_ff <= 1'b1;
        end else if (clear_done) begin
            done_ff <= 1'b0;
        end
    end

    // the verdict is taken when a self-test operation ends
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            test_pend_ff <= 1'b0;
            pass_ff      <= 1'b0;
            failed_ff    <= 1'b0;
        end else begin
            if (start_req) begin
                test_pend_ff <= self_test_ff;
            end else if (op_done) begin
                test_pend_ff <= 1'b0;
            end
            if (op_done && test_pend_ff) begin
                pass_ff   <= test_ok;
                failed_ff <= failed_ff | ~test_ok;
            end
        end
    end

    // ************************************************************
    // interrupt status, mask and request
    // ************************************************************
    assign irq_events = {op_done & test_pend_ff & ~test_ok, op_done};

    // write one to clear; a new event wins over the clear
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            irq_stat_ff <= 2'h0;
            irq_mask_ff <= 2'h0;
        end else begin
            if (wr_en && paddr == `CEM_OFF_IRQ_STATUS) begin
                irq_stat_ff <= (irq_stat_ff & ~pwdata[1:0]) | irq_events;
            end else if (clear_done) begin
                irq_stat_ff <= (irq_stat_ff & 2'h2) | irq_events;
            end else begin
                irq_stat_ff <= irq_stat_ff | irq_events;
            end
            if (wr_en && paddr == `CEM_OFF_IRQ_MASK) begin
                irq_mask_ff <= pwdata[1:0];
            end
        end
    end

    // done-driven request, gated by the mode mask bit
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_stat_ff & ~irq_mask_ff) & done_ff &
                      ~mask_irq_ff;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign prdata        = prdata_ff;
    assign pready        = pready_ff;
    assign pslverr       = pslverr_ff;
    assign engine_enable = on_ff;
    assign normal_key    = normal_ff;
    assign bypass        = bypass_ff;
    assign result_zero   = failed_ff;
    assign clear_mem     = clear_mem_ff;
    assign load_mac      = load_mac_ff;
    assign irq           = irq_ff;

endmodule : cem_mode_ctrl
`default_nettype wire

/* tb/cem_mode_ctrl_properties.sv */
/* concurrent checks on the ports of the cipher engine mode control block.
   assumes: bound onto cem_mode_ctrl; one clock, async active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module cem_mode_ctrl_props #(
    parameter logic [4:0] PHASE_CYCLES = 5'h0d
) (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        test_ok,
    input wire logic        engine_enable,
    input wire logic        normal_key,
    input wire logic        bypass,
    input wire logic        run_ctr,
    input wire logic        run_mac,
    input wire logic        run_test,
    input wire logic        busy,
    input wire logic        result_zero,
    input wire logic        clear_mem,
    input wire logic        load_mac,
    input wire logic        irq
);
    // ************
    // helper logic
    // ************
    logic       wr_mode;
    logic       start_ok;
    logic [5:0] mode_ff; // mask, test, ctr, mac, bypass, on

    // applied mode writes and accepted starts as seen on the bus
    assign wr_mode  = psel && penable && pready && pwrite && paddr == 8'h54;
    assign start_ok = psel && penable && pready && pwrite && paddr == 8'h50
                      && pwdata[24] && !busy && engine_enable && !result_zero;

    // mirror of the mode bits as software wrote them
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            mode_ff <= 6'h00;
        end else if (wr_mode) begin
            mode_ff <= {pwdata[31], pwdata[26:24], pwdata[2], pwdata[0]};
        end
    end

    // ************
    // properties
    // ************
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // one cipher phase: high for thirteen clocks, then low
    sequence s_phase(s);
        s[*8] ##1 s[*5] ##1 !s;
    endsequence

    a_ctr_phase: assert property ($rose(run_ctr) |-> s_phase(run_ctr))
        else $error("counter phase length wrong");
    a_mac_phase: assert property ($rose(run_mac) |-> s_phase(run_mac))
        else $error("mac phase length wrong");
    a_test_phase: assert property (
        $rose(run_test) |-> s_phase(run_test))
        else $error("self test phase length wrong");
    a_dual_order: assert property (
        start_ok && mode_ff[4:2] == 3'b011 |=>
        (run_ctr && !run_mac)[*8] ##1 (run_ctr && !run_mac)[*5]
        ##1 s_phase(run_mac))
        else $error("dual operation order or length wrong");
    a_test_first: assert property (start_ok && mode_ff[4] |=>
        run_test && !run_ctr && !run_mac)
        else $error("self test did not take priority");
    a_irq_masked: assert property (
        mode_ff[5] && $past(mode_ff[5]) |-> !irq)
        else $error("irq raised while masked");
    a_mode_outs: assert property (engine_enable == mode_ff[0]
        && bypass == mode_ff[1])
        else $error("enable or bypass differs from written bits");
    a_normal_set: assert property (wr_mode && pwdata[1] |=> normal_key)
        else $error("normal key not selected after write");
    a_normal_keep: assert property (normal_key |=> normal_key)
        else $error("normal key dropped without reset");
    a_fail_keep: assert property (result_zero |=> result_zero)
        else $error("failed state left without reset");
    a_busy_cause: assert property (
        $rose(busy) |-> $past(start_ok))
        else $error("operation began without an accepted start");
    a_reserved_zero: assert property (
        psel && penable && pready && !pwrite
        && paddr == 8'h54 |-> prdata[30:27] == 4'h0 && prdata[23:3] == 21'h0)
        else $error("reserved mode bits read nonzero");
endmodule : cem_mode_ctrl_props

bind cem_mode_ctrl cem_mode_ctrl_props #(
    .PHASE_CYCLES(PHASE_CYCLES)
) cem_mode_ctrl_props_i (.*);
`default_nettype wire

/* tb/cem_mode_ctrl_tb_top.sv */
/* self-checking bench of the cipher engine mode control block.
   assumes: checker bound separately; this bench is the apb master. */
`timescale 1ns/1ps
`default_nettype none
module cem_mode_ctrl_tb_top;
    // ************
    // signals
    // ************
    localparam int          PH = 13;
    localparam logic [31:0] RW = 32'h8700_0007;
    logic        clock, reset, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q, m;
    logic        test_ok, engine_enable, normal_key, bypass, busy, irq;
    logic        run_ctr, run_mac, run_test, result_zero;
    logic        clear_mem, load_mac, err, nk;
    int          n_fail, n_tests, cyc, seed, nc, nm, nt, i;
    logic [31:0] tbl [0:6] = '{32'h0200_0001, 32'h0100_0001, 32'h0300_0001,
        32'h0700_0001, 32'h0200_0000, 32'h0000_0001, 32'h8300_0005};

    cem_mode_ctrl #(.PHASE_CYCLES(5'h0d)) cem_mode_ctrl_i (.*);

    // free-running clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    // ************
    // tasks
    // ************
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q       = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // let registered outputs follow the last write
    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask : settle

    // phase clocks that a start in mode word w should give
    function automatic logic [23:0] exp_run(input logic [31:0] w);
        logic [23:0] r;
        r = 24'h0;
        if (w[0] && w[26]) begin
            r[7:0] = 8'(PH);
        end else if (w[0]) begin
            r[23:16] = w[25] ? 8'(PH) : 8'h00;
            r[15:8]  = w[24] ? 8'(PH) : 8'h00;
        end
        return r;
    endfunction : exp_run

    // start in mode w and count the clocks of each phase
    task automatic run_op(input logic [31:0] w, input logic refused);
        logic [31:0] seen;
        logic [31:0] want;
        apb(1'b1, 8'h54, w);
        apb(1'b1, 8'h50, 32'h0100_0000);
        nc = 0;
        nm = 0;
        nt = 0;
        #1;
        for (int k = 0; k < 100 && busy === 1'b1; k++) begin
            nc += int'(run_ctr === 1'b1);
            nm += int'(run_mac === 1'b1);
            nt += int'(run_test === 1'b1);
            @(posedge clock);
            #1;
        end
        seen = {8'h0, 8'(nc), 8'(nm), 8'(nt)};
        want = refused ? 32'h0 : {8'h0, exp_run(w)};
        check("phase clocks", seen, want);
    endtask : run_op

    // verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    // ************
    // main sequence
    // ************
    initial begin
        reset   = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        test_ok = 1'b1;
        seed    = 32'h7eab;
        nk      = 1'b0;
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        apb(1'b0, 8'h54, 32'h0);
        check("mode reset", q, 32'h0);
        check("boot key", 32'(normal_key), 32'h0);
        apb(1'b0, 8'h74, 32'h0);
        check("mask reset", q, 32'h0);
        // operations per mode word, table then random
        for (i = 0; i < 11; i++) begin
            m = (i < 7) ? tbl[i] : ($random(seed) & 32'h8700_0005);
            run_op(m, 1'b0);
            apb(1'b0, 8'h54, 32'h0);
            check("mode readback", q, m & RW);
            apb(1'b0, 8'h58, 32'h0);
            check("done flag", 32'(q[26]), 32'(exp_run(m) != 0));
            check("irq level", 32'(irq),
                  32'(exp_run(m) != 0 && !m[31]));
            if (irq === 1'b1) begin
                apb(1'b1, 8'h74, 32'h1);
                settle();
                check("irq masked", 32'(irq), 32'h0);
                apb(1'b1, 8'h74, 32'h0);
                settle();
                check("irq unmasked", 32'(irq), 32'h1);
                apb(1'b1, 8'h70, 32'h1);
                settle();
                check("irq cleared", 32'(irq), 32'h0);
            end
            apb(1'b1, 8'h50, 32'h8000_0000);
            apb(1'b0, 8'h58, 32'h0);
            check("done cleared", 32'(q[26]), 32'h0);
        end
        // mode writes: corners, then random words
        for (i = 0; i < 8; i++) begin
            m = (i == 0) ? 32'hffff_fffd : (i == 1) ? 32'hffff_ffff :
                (i == 2) ? 32'h0 : $random(seed);
            nk = nk | m[1];
            apb(1'b1, 8'h54, m);
            #1;
            check("no launch", 32'(busy), 32'h0);
            check("outputs",
                  {engine_enable, bypass, normal_key}, {m[0], m[2], nk});
            apb(1'b0, 8'h54, 32'h0);
            check("mode word", q,
                  (m & RW) | {30'h0, nk, 1'b0});
        end
        apb(1'b0, 8'h04, 32'h0);
        check("unmapped err", 32'(err), 32'h1);
        check("unmapped data", q, 32'h0);
        // housekeeping strobes give one-cycle pulses
        apb(1'b1, 8'h50, 32'h0600_0000);
        #1;
        check("pulses", {30'h0, clear_mem, load_mac}, 32'h3);
        @(posedge clock);
        #1;
        check("pulses end", {30'h0, clear_mem, load_mac}, 32'h0);
        // failing self test locks the engine
        @(posedge clock);
        test_ok <= 1'b0;
        run_op(32'h0400_0001, 1'b0);
        settle();
        check("fail zeroes", 32'(result_zero), 32'h1);
        apb(1'b0, 8'h58, 32'h0);
        check("test verdict", 32'(q[25]), 32'h0);
        @(posedge clock);
        test_ok <= 1'b1;
        run_op(32'h0200_0001, 1'b1);
        // second reset returns to boot mode
        @(posedge clock);
        reset <= 1'b1;
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        #1;
        check("boot again",
              {30'h0, normal_key, result_zero}, 32'h0);
        complete_run();
    end
endmodule : cem_mode_ctrl_tb_top
`default_nettype wire
